// ---- hw/standby_consts.vh ----
`ifndef STANDBY_CONSTS_VH
`define STANDBY_CONSTS_VH
// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define ADDR_CTRL_TWO     4'h0
`define ADDR_CTRL_ZERO    4'h4
`define ADDR_IDLE_SEL     4'h8
`define ADDR_MASK_LEVEL   4'hc
`define ADDR_HALT_CMD     4'h0
`define ADDR_STATUS       4'h4
// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define TWO_WARMUP_LO     1
`define TWO_WARMUP_HI     2
`define TWO_DRIVE_BIT     0
`define TWO_HALT_LO       3
`define TWO_HALT_HI       4
`define ZERO_RESUME_BIT   0
`define ZERO_HIGH_EN_BIT  1
`define ZERO_LOW_EN_BIT   2
`define TWO_RESET         5'h00
`define ZERO_RESET        3'h2
`define IDLE_SEL_RESET    8'h00
`define MASK_RESET        3'h0
// ----------------------------------------------------------------
// Halt kinds and warm-up exponents
// ----------------------------------------------------------------
`define HALT_LIGHT        2'h0
`define HALT_DEEP         2'h1
`define HALT_STOP         2'h2
`define WARM_8            2'h1
`define WARM_14           2'h2
`define WARM_16           2'h3
`define WARM_LEN_8        17'h00100
`define WARM_LEN_14       17'h04000
`define WARM_LEN_16       17'h10000
`define WARM_LEN_NONE     17'h00001
`define ENTRY_CLOCKS      3'h5
`define NMI_LEVEL         3'h7
`endif

// ---- hw/warmup_counter.v ----
`timescale 1ns/10ps
`include "standby_consts.vh"

module warmup_counter (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // Control
  input  wire        start,
  input  wire        osc_tick,
  input  wire [1:0]  count_sel,
  // Status
  output reg         done
);

  reg [16:0] count;
  reg        running;

  // Terminal count for the selected warm-up length
  function [16:0] terminal;
    input [1:0] sel;
    begin
      case (sel)
        `WARM_8:  terminal = `WARM_LEN_8;
        `WARM_14: terminal = `WARM_LEN_14;
        `WARM_16: terminal = `WARM_LEN_16;
        default:  terminal = `WARM_LEN_NONE;
      endcase
    end
  endfunction

  // Cleared at every start, counts resuming oscillator ticks
  always @(posedge aclk) begin
    if (!aresetn) begin
      count   <= 17'h00000;
      running <= 1'b0;
      done    <= 1'b0;
    end else if (start) begin
      count   <= 17'h00000;
      running <= 1'b1;
      done    <= 1'b0;
    end else if (running && osc_tick) begin
      if (count + 17'h00001 >= terminal(count_sel)) begin
        running <= 1'b0;
        done    <= 1'b1;
      end
      count <= count + 17'h00001;
    end else begin
      done <= 1'b0;
    end
  end

endmodule // warmup_counter

// ---- hw/standby_mode_controller.v ----
// Summary of operation
// - Light idle keeps only peripherals enabled in the idle select register.
// - CPU fetch and execute stay stopped throughout light idle.
// - Deep idle keeps only oscillator and clock timer running.
// - Deep idle gates the system clock to CPU and peripherals.
// - Interrupts are caught while halted without needing the system clock.
// - Restart after halt is issued on a system clock edge.
// - Stop halts every circuit including the oscillator.
// - Pin drive during stop follows the stop pin drive select bit.
// - After stop, system clock stays off until warm-up elapses.
// - Resume clock select: 0 high frequency, 1 low frequency.
// - Warm-up select 01, 10, 11 give 2^8, 2^14, 2^16 cycles.
// - External interrupt zero releases deep idle.
// - Stop entered on low clock may resume on high clock after NMI.
// - Interrupt at or above mask level releases light idle and is serviced.
// - Ext irqs zero to four release any halt even masked; clock timer releases light and deep idle only, not stop.
// - Interrupt during five-clock entry is held pending for later.
// - Interrupt release from stop completes only after warm-up.
`timescale 1ns/10ps
`include "standby_consts.vh"

module standby_mode_controller #(
  parameter N_PERIPH = 8
) (
  // Clock and reset
  input  wire                 aclk,
  input  wire                 aresetn,
  // AXI4-Lite write address
  input  wire [3:0]           s_axi_awaddr,
  input  wire                 s_axi_awvalid,
  output reg                  s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]          s_axi_wdata,
  input  wire [3:0]           s_axi_wstrb,
  input  wire                 s_axi_wvalid,
  output reg                  s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]           s_axi_bresp,
  output reg                  s_axi_bvalid,
  input  wire                 s_axi_bready,
  // AXI4-Lite read address
  input  wire [3:0]           s_axi_araddr,
  input  wire                 s_axi_arvalid,
  output reg                  s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0]          s_axi_rdata,
  output reg  [1:0]           s_axi_rresp,
  output reg                  s_axi_rvalid,
  input  wire                 s_axi_rready,
  // CPU core side
  input  wire                 halt_exec,
  output reg                  cpu_run,
  output reg                  irq_service,
  output reg  [2:0]           irq_service_level,
  output reg                  resume_next,
  // Interrupt sources
  input  wire                 nmi_req,
  input  wire [4:0]           ext_irq_req,
  input  wire                 clock_timer_irq,
  input  wire [2:0]           irq_level,
  input  wire                 irq_other,
  // Oscillator ticks
  input  wire                 high_osc_tick,
  input  wire                 low_osc_tick,
  // Clock and power controls
  output reg                  sys_clk_enable,
  output reg                  high_osc_run,
  output reg                  low_osc_run,
  output reg                  sys_on_low_clock,
  output reg                  clock_timer_run,
  output reg  [N_PERIPH-1:0]  periph_clk_enable,
  output reg                  stop_pin_drive
);

  // ----------------------------------------------------------------
  // Local states
  // ----------------------------------------------------------------
  localparam ST_RUN   = 3'h0;
  localparam ST_ENTER = 3'h1;
  localparam ST_LIGHT = 3'h2;
  localparam ST_DEEP  = 3'h3;
  localparam ST_STOP  = 3'h4;
  localparam ST_WARM  = 3'h5;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [4:0]          system_ctrl_reg_two;
  reg [2:0]          system_ctrl_reg_zero;
  reg [7:0]          idle_sel;
  reg [2:0]          irq_mask_level;
  reg [2:0]          state;
  reg [2:0]          next_state;
  reg [2:0]          entry_count;
  reg                pend;
  reg [2:0]          pend_level;
  reg                pend_masked;
  reg                warm_start;
  reg                aw_held;
  reg                w_held;
  reg [3:0]          aw_addr;
  reg [31:0]         w_data;
  reg [3:0]          w_strb;
  wire               warm_done;

  wire [1:0] warmup_count_sel =
             system_ctrl_reg_two[`TWO_WARMUP_HI:`TWO_WARMUP_LO];
  wire [1:0] halt_sel         = system_ctrl_reg_two[`TWO_HALT_HI:`TWO_HALT_LO];
  wire       resume_low       = system_ctrl_reg_zero[`ZERO_RESUME_BIT];
  wire       resume_high_osc_enable = system_ctrl_reg_zero[`ZERO_HIGH_EN_BIT];
  wire       resume_low_osc_enable  = system_ctrl_reg_zero[`ZERO_LOW_EN_BIT];

  // ----------------------------------------------------------------
  // Release decode
  // ----------------------------------------------------------------
  // Request lines are levels that are read with no clock-gated stage,
  // so a request is seen even with the system clock held off.
  wire enabled_lvl = (irq_level >= irq_mask_level);
  wire masked_wake = |ext_irq_req | clock_timer_irq;
  function wake_ok;
    input [2:0] st;
    input       nmi;
    input [4:0] ext;
    input       rtc;
    input       other;
    input       en;
    begin
      case (st)
        ST_LIGHT: wake_ok = nmi | ((other | |ext | rtc) & en)
                            | |ext | rtc;
        ST_DEEP:  wake_ok = nmi | ext[0] | |ext | rtc;
        ST_STOP:  wake_ok = nmi | |ext;
        default:  wake_ok = 1'b0;
      endcase
    end
  endfunction
  wire wake_now = wake_ok(state, nmi_req, ext_irq_req, clock_timer_irq,
                          irq_other, enabled_lvl);
  wire any_wake_src = nmi_req | masked_wake;
  wire service_now = nmi_req | enabled_lvl;

  // ----------------------------------------------------------------
  // Halt state machine
  // ----------------------------------------------------------------
  always @* begin
    next_state = state;
    case (state)
      ST_RUN:
        if (halt_exec) begin
          if (halt_sel == `HALT_LIGHT)
            next_state = ST_LIGHT;
          else
            next_state = ST_ENTER;
        end
      ST_ENTER:
        if (entry_count == `ENTRY_CLOCKS - 3'h1) begin
          next_state = (halt_sel == `HALT_STOP) ? ST_STOP : ST_DEEP;
        end
      ST_LIGHT:
        if (wake_now) next_state = ST_RUN;
      ST_DEEP:
        // A request held from entry waits for a fresh release
        if (wake_now) next_state = ST_RUN;
      ST_STOP:
        if (wake_now) next_state = ST_WARM;
      ST_WARM:
        if (warm_done) next_state = ST_RUN;
      default:
        next_state = ST_RUN;
    endcase
  end

  // Restart and service are issued on the clock edge only
  always @(posedge aclk) begin
    if (!aresetn) begin
      state             <= ST_RUN;
      entry_count       <= 3'h0;
      pend              <= 1'b0;
      pend_level        <= 3'h0;
      pend_masked       <= 1'b0;
      warm_start        <= 1'b0;
      irq_service       <= 1'b0;
      irq_service_level <= 3'h0;
      resume_next       <= 1'b0;
      sys_on_low_clock  <= 1'b0;
    end else begin
      state       <= next_state;
      warm_start  <= 1'b0;
      irq_service <= 1'b0;
      resume_next <= 1'b0;
      entry_count <= (state == ST_ENTER) ? entry_count + 3'h1 : 3'h0;
      // A request in the entry window is held, not lost
      if (state == ST_ENTER && any_wake_src) begin
        pend        <= 1'b1;
        pend_level  <= nmi_req ? `NMI_LEVEL : irq_level;
        pend_masked <= ~service_now;
      end
      if (state == ST_STOP && next_state == ST_WARM)
        warm_start <= 1'b1;
      if (state != ST_RUN && state != ST_ENTER && next_state == ST_RUN) begin
        // Held request is serviced first unless irq_level exceeds pend_level
        if (pend && (!wake_now || pend_level >= irq_level)) begin
          irq_service       <= ~pend_masked;
          irq_service_level <= pend_level;
          resume_next       <= pend_masked;
          pend              <= wake_now;
          pend_level        <= nmi_req ? `NMI_LEVEL : irq_level;
          pend_masked       <= ~service_now;
        end else begin
          irq_service       <= service_now;
          irq_service_level <= nmi_req ? `NMI_LEVEL : irq_level;
          resume_next       <= ~service_now;
        end
        if (state == ST_WARM)
          sys_on_low_clock <= resume_low;
      end
      // The other of two requests follows one idle cycle after the first
      if (state == ST_RUN && pend && !irq_service && !resume_next) begin
        irq_service       <= ~pend_masked;
        irq_service_level <= pend_level;
        resume_next       <= pend_masked;
        pend              <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Clock and power gating
  // ----------------------------------------------------------------
  // Outputs registered from the next state so they track it directly
  always @(posedge aclk) begin
    if (!aresetn) begin
      cpu_run           <= 1'b1;
      sys_clk_enable    <= 1'b1;
      high_osc_run      <= 1'b1;
      low_osc_run       <= 1'b1;
      clock_timer_run   <= 1'b1;
      periph_clk_enable <= {N_PERIPH{1'b1}};
      stop_pin_drive    <= 1'b0;
    end else begin
      cpu_run        <= (next_state == ST_RUN || next_state == ST_ENTER);
      sys_clk_enable <= ~(next_state == ST_DEEP || next_state == ST_STOP
                          || next_state == ST_WARM);
      clock_timer_run <= (next_state != ST_STOP);
      stop_pin_drive <= (next_state == ST_STOP) &
                        system_ctrl_reg_two[`TWO_DRIVE_BIT];
      case (next_state)
        ST_LIGHT: periph_clk_enable <= idle_sel[N_PERIPH-1:0];
        ST_RUN, ST_ENTER: periph_clk_enable <= {N_PERIPH{1'b1}};
        default:  periph_clk_enable <= {N_PERIPH{1'b0}};
      endcase
      if (next_state == ST_STOP) begin
        high_osc_run <= 1'b0;
        low_osc_run  <= 1'b0;
      end else if (next_state == ST_WARM) begin
        high_osc_run <= resume_high_osc_enable;
        low_osc_run  <= resume_low_osc_enable;
      end
    end
  end

  // ----------------------------------------------------------------
  // Warm-up counter on the resuming oscillator
  // ----------------------------------------------------------------
  warmup_counter u_warm (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .start     (warm_start),
    .osc_tick  (resume_low ? low_osc_tick : high_osc_tick),
    .count_sel (warmup_count_sel),
    .done      (warm_done)
  );

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  // Write: address and data captured in either order, then one response
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready        <= 1'b1;
      s_axi_wready         <= 1'b1;
      s_axi_bvalid         <= 1'b0;
      s_axi_bresp          <= 2'h0;
      aw_held              <= 1'b0;
      w_held               <= 1'b0;
      aw_addr              <= 4'h0;
      w_data               <= 32'h00000000;
      w_strb               <= 4'h0;
      system_ctrl_reg_two  <= `TWO_RESET;
      system_ctrl_reg_zero <= `ZERO_RESET;
      idle_sel             <= `IDLE_SEL_RESET;
      irq_mask_level       <= `MASK_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (aw_held && w_held && !s_axi_bvalid) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'h0;
        if (w_strb[0]) begin
          case (aw_addr)
            `ADDR_CTRL_TWO:   system_ctrl_reg_two  <= w_data[4:0];
            `ADDR_CTRL_ZERO:  system_ctrl_reg_zero <= w_data[2:0];
            `ADDR_IDLE_SEL:   idle_sel             <= w_data[7:0];
            `ADDR_MASK_LEVEL: irq_mask_level       <= w_data[2:0];
            default:          s_axi_bresp          <= 2'h2;
          endcase
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Read: one cycle after address, status shows live halt state
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= 2'h0;
      case (s_axi_araddr)
        `ADDR_CTRL_TWO:   s_axi_rdata <= {27'h0, system_ctrl_reg_two};
        `ADDR_CTRL_ZERO:  s_axi_rdata <= {29'h0, system_ctrl_reg_zero};
        `ADDR_IDLE_SEL:   s_axi_rdata <= {24'h0, idle_sel};
        `ADDR_MASK_LEVEL: s_axi_rdata <= {25'h0, pend, 3'h0, irq_mask_level}
                                         | {24'h0, 1'b0, state, 4'h0};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule // standby_mode_controller

// ---- tb/standby_checker_assertions.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// Standby controller property checker
// ----------------------------------------
module standby_checker #(
  parameter N_PERIPH = 8
) (
  // Clock and reset
  input wire                aclk,
  input wire                aresetn,
  // Core side
  input wire                halt_exec,
  input wire                cpu_run,
  input wire                irq_service,
  input wire                resume_next,
  // Clock and power
  input wire                high_osc_tick,
  input wire                low_osc_tick,
  input wire                sys_clk_enable,
  input wire                high_osc_run,
  input wire                low_osc_run,
  input wire                clock_timer_run,
  input wire [N_PERIPH-1:0] periph_clk_enable,
  input wire                stop_pin_drive
);
  reg        was_stop;
  reg [17:0] ticks;

  // Ticks counted while the system clock is off; cleared once it returns
  always @(posedge aclk) begin
    if (!aresetn || sys_clk_enable) begin
      was_stop <= 1'b0;
      ticks    <= 18'h0;
    end else begin
      if (!high_osc_run && !low_osc_run)
        was_stop <= 1'b1;
      if (high_osc_tick || low_osc_tick)
        ticks <= ticks + 18'h1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_halt_stops_cpu: assert property (
    cpu_run && halt_exec |-> ##[1:8] !cpu_run)
    else $error("CPU kept running after a halt");
  chk_gated_no_cpu: assert property (
    !sys_clk_enable |-> !cpu_run)
    else $error("CPU runs with the system clock gated");
  chk_deep_only_timer: assert property (
    clock_timer_run && !sys_clk_enable |-> periph_clk_enable == '0)
    else $error("Peripheral clock left on in deep idle");
  chk_stop_all_off: assert property (
    !high_osc_run && !low_osc_run
      |-> !sys_clk_enable && !clock_timer_run && periph_clk_enable == '0)
    else $error("Circuit still clocked in stop");
  chk_drive_in_stop: assert property (
    stop_pin_drive |-> !sys_clk_enable)
    else $error("Stop pin drive outside a halt");
  chk_warm_needs_ticks: assert property (
    was_stop && $rose(sys_clk_enable) |-> ticks != 18'h0)
    else $error("System clock back without warm-up ticks");
  chk_service_pulse: assert property (
    irq_service |=> !irq_service)
    else $error("Service pulse longer than one cycle");
  chk_resume_alone: assert property (
    resume_next |-> !irq_service ##1 !resume_next)
    else $error("Masked wake pulse malformed");
  chk_release_runs: assert property (
    irq_service || resume_next |-> ##[0:2] cpu_run)
    else $error("Wake without restart of the CPU");

  // Main scenarios reached
  cov_service: cover property (irq_service);
  cov_resume: cover property (resume_next);
  cov_stop_exit: cover property (was_stop && $rose(sys_clk_enable));
endmodule // standby_checker

bind standby_mode_controller standby_checker #(.N_PERIPH(N_PERIPH)) u_chk (
  .aclk, .aresetn, .halt_exec, .cpu_run, .irq_service, .resume_next,
  .high_osc_tick, .low_osc_tick, .sys_clk_enable, .high_osc_run,
  .low_osc_run, .clock_timer_run, .periph_clk_enable, .stop_pin_drive);

// ---- tb/osc_cpu_model.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// CPU halt issue and oscillator model
// ----------------------------------------
module osc_cpu_model (
  // Clock and reset
  input  wire aclk,
  input  wire aresetn,
  // CPU side
  input  wire halt_cmd,
  input  wire cpu_run,
  output reg  halt_exec,
  // Oscillators
  input  wire high_osc_run,
  input  wire low_osc_run,
  output reg  high_osc_tick,
  output reg  low_osc_tick
);
  // Halt only issues from a running core; a stopped oscillator never ticks
  always @(posedge aclk) begin
    if (!aresetn) begin
      halt_exec     <= 1'b0;
      high_osc_tick <= 1'b0;
      low_osc_tick  <= 1'b0;
    end else begin
      halt_exec     <= halt_cmd & cpu_run;
      high_osc_tick <= high_osc_run;
      low_osc_tick  <= low_osc_run;
    end
  end
endmodule // osc_cpu_model

// ---- tb/standby_mode_controller_bench.sv ----
`timescale 1ns/10ps
`include "standby_consts.vh"
// ----------------------------------------
// Standby controller bench
// ----------------------------------------
module standby_mode_controller_bench;
  reg         aclk = 1'b0, aresetn = 1'b0;
  reg  [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
  reg  [31:0] s_axi_wdata = 32'h0;
  reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  reg         s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire        s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  reg         halt_cmd = 1'b0, nmi_req = 1'b0, irq_other = 1'b0;
  reg         clock_timer_irq = 1'b0;
  reg  [4:0]  ext_irq_req = 5'h0;
  reg  [2:0]  irq_level = 3'h0;
  wire        halt_exec, cpu_run, irq_service, resume_next, stop_pin_drive;
  wire        high_osc_tick, low_osc_tick, high_osc_run, low_osc_run;
  wire        sys_clk_enable, sys_on_low_clock, clock_timer_run;
  wire [2:0]  irq_service_level;
  wire [7:0]  periph_clk_enable;
  integer     n_errors = 0, total_checks = 0, cycles = 0, n, e, k;
  reg  [31:0] rd;
  reg  [1:0]  bresp_seen, rresp_seen;

  standby_mode_controller #(.N_PERIPH(8)) DUT (.*);
  osc_cpu_model u_model (.*);

  // Free-running clock and a watchdog on the whole run
  always #50 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles = cycles + 1;
    if (cycles == 90000) begin
      n_errors = n_errors + 1;
      results;
    end
  end

  task check(input [31:0] seen, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
    end
  endtask

  // Write: address and data offered together, each dropped once taken
  task wr(input [3:0] a, input [31:0] d, input [3:0] s);
    begin
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      do begin
        @(posedge aclk);
        if (s_axi_awvalid && s_axi_awready)
          s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready)
          s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      bresp_seen = s_axi_bresp;
    end
  endtask

  task rdr(input [3:0] a, output [31:0] d);
    begin
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      do begin
        @(posedge aclk);
        if (s_axi_arvalid && s_axi_arready)
          s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      rresp_seen = s_axi_rresp;
    end
  endtask

  task halt;
    begin
      halt_cmd <= 1'b1;
      @(posedge aclk);
      halt_cmd <= 1'b0;
    end
  endtask

  // Wait for the one-cycle wake pulse, checked in the cycle it stands
  task wake_wait;
    while (irq_service !== 1'b1 && resume_next !== 1'b1)
      @(posedge aclk);
  endtask

  task results;
    begin
      $display("Checks %0d, errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Reset values, then a write without byte lane zero is ignored
    rdr(`ADDR_CTRL_TWO, rd);
    check(rd & 32'h1f, {27'h0, `TWO_RESET});
    rdr(`ADDR_CTRL_ZERO, rd);
    check(rd & 32'h7, {29'h0, `ZERO_RESET});
    wr(`ADDR_IDLE_SEL, 32'h5a, 4'he);
    rdr(`ADDR_IDLE_SEL, rd);
    check(rd & 32'hff, {24'h0, `IDLE_SEL_RESET});
    check(bresp_seen, 32'h0);
    check(rresp_seen, 32'h0);
    // Unmapped offsets answer with an error and change nothing
    wr(4'h2, 32'h1f, 4'h1);
    check(bresp_seen, 32'h2);
    rdr(4'h2, rd);
    check(rd, 32'h0);
    check(rresp_seen, 32'h2);
    $display("test registers done");
    // Light idle keeps only selected peripherals, wake by level >= mask
    wr(`ADDR_IDLE_SEL, 32'h05, 4'h1);
    wr(`ADDR_MASK_LEVEL, 32'h0, 4'h1);
    wr(`ADDR_CTRL_TWO, 32'h00, 4'h1);
    halt;
    while (cpu_run) @(posedge aclk);
    repeat (2) @(posedge aclk);
    check(periph_clk_enable, 32'h05);
    check(cpu_run, 32'h0);
    irq_other <= 1'b1;
    irq_level <= 3'h3;
    wake_wait;
    check(irq_service, 32'h1);
    check(irq_service_level, 32'h3);
    irq_other <= 1'b0;
    while (!cpu_run) @(posedge aclk);
    $display("test light idle done");
    // Deep idle, masked external zero resumes without service
    wr(`ADDR_MASK_LEVEL, 32'h7, 4'h1);
    wr(`ADDR_CTRL_TWO, 32'h08, 4'h1);
    halt;
    while (sys_clk_enable) @(posedge aclk);
    repeat (2) @(posedge aclk);
    check(clock_timer_run, 32'h1);
    check(periph_clk_enable, 32'h0);
    ext_irq_req <= 5'h01;
    irq_level   <= 3'h1;
    wake_wait;
    check(resume_next, 32'h1);
    check(irq_service, 32'h0);
    ext_irq_req <= 5'h00;
    while (!cpu_run) @(posedge aclk);
    check(sys_clk_enable, 32'h1);
    $display("test deep idle done");
    // Request inside the entry window is held, served first later
    wr(`ADDR_MASK_LEVEL, 32'h0, 4'h1);
    halt;
    @(posedge aclk);
    nmi_req   <= 1'b1;
    irq_level <= `NMI_LEVEL;
    @(posedge aclk);
    nmi_req <= 1'b0;
    while (sys_clk_enable) @(posedge aclk);
    repeat (10) @(posedge aclk);
    check(cpu_run, 32'h0);
    ext_irq_req <= 5'h01;
    irq_level   <= 3'h2;
    wake_wait;
    check(irq_service_level, {29'h0, `NMI_LEVEL});
    ext_irq_req <= 5'h00;
    @(posedge aclk);
    wake_wait;
    check(irq_service_level, 32'h2);
    repeat (20) @(posedge aclk);
    $display("test entry window done");
    // Stop with each warm-up length; middle pass resumes on the low clock
    for (k = 1; k <= 3; k = k + 1) begin
      e = (k == 1) ? 256 : (k == 2) ? 16384 : 65536;
      wr(`ADDR_CTRL_ZERO, (k == 2) ? 32'h7 : 32'h6, 4'h1);
      wr(`ADDR_CTRL_TWO, 32'h11 | (k << 1), 4'h1);
      halt;
      while (high_osc_run || low_osc_run) @(posedge aclk);
      @(posedge aclk);
      check(stop_pin_drive, 32'h1);
      check(sys_clk_enable, 32'h0);
      nmi_req   <= 1'b1;
      irq_level <= `NMI_LEVEL;
      n = 0;
      while (!sys_clk_enable) begin
        @(posedge aclk);
        if ((k == 2) ? low_osc_tick : high_osc_tick)
          n = n + 1;
      end
      nmi_req <= 1'b0;
      check(n >= e && n <= e + 4, 32'h1);
      check(sys_on_low_clock, (k == 2) ? 32'h1 : 32'h0);
      wake_wait;
      check(irq_service_level, {29'h0, `NMI_LEVEL});
      repeat (4) @(posedge aclk);
    end
    $display("test stop warm-up done");
    results;
  end
endmodule // standby_mode_controller_bench
